/* File: cab_core.sv */
`timescale 1ns/1ps
// Functional notes
// - add registers, optionally plus carry; all arithmetic flags; one clock.
// - subtract register or immediate; store; arithmetic flags; one clock.
// - subtract with borrow, register or immediate; arithmetic flags; one clock.
// - word add immediate to pair; Z C N V S flags; two clocks.
// - word subtract immediate from pair; Z C N V S flags; two clocks.
// - and, or, xor set Z N V S only, carry kept; one clock.
// - set mask ORs, clear mask ANDs inverted mask; Z N V; one clock.
// - test ANDs register with itself, zero XORs it; Z N V.
// - multiplies put 16-bit product in R1:R0; Z and C; two clocks.
// - fractional multiplies shift product left one; Z and C; two clocks.
// - relative and pointer calls three clocks; direct call four clocks.
// - compares subtract without writeback; all arithmetic flags; one clock.
// - compare-skip equal skips next instruction; no flags; one to three clocks.
// - skip on register bit clear or set; no flags.
// - skip on I/O bit clear or set; no flags.
// - branch on status bit set or clear to PC+k+1; one or two clocks.
// - signed ge when N xor V is 0, less when 1.
// - same-or-higher when carry 0, lower when carry 1.
// - half-carry and T branches test that single flag.
// - overflow-set branch taken when V is 1.
module cab_core (
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  // decoded instruction
  input  wire logic        issue_in,
  input  wire logic [5:0]  op_in,
  input  wire logic [7:0]  rd_val_in,
  input  wire logic [7:0]  rr_val_in,
  input  wire logic [7:0]  rd_hi_in,
  input  wire logic [7:0]  imm_in,
  input  wire logic [2:0]  bit_sel_in,
  input  wire logic [7:0]  io_val_in,
  input  wire logic [15:0] k_in,
  input  wire logic [15:0] z_ptr_in,
  input  wire logic        use_imm_in,
  input  wire logic        next_two_word_in,
  // register file writeback
  output logic             wr_en_out,
  output logic             wr_word_out,
  output logic             wr_prod_out,
  output logic [7:0]       wr_lo_out,
  output logic [7:0]       wr_hi_out,
  // flow and status
  output logic [15:0]      pc_out,
  output logic             busy_out,
  output logic [7:0]       status_flags_reg_out
);
  cab_alu_if alu ();

  cab_adder u_adder (
    .bus (alu.adder)
  );

  cab_mult u_mult (
    .bus (alu.mult)
  );

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } cab_state_e;

  cab_state_e  state_reg;
  logic [1:0]  wait_reg;
  logic [15:0] pc_reg;
  logic [7:0]  status_flags_reg;
  logic        wr_en_reg;
  logic        wr_word_reg;
  logic        wr_prod_reg;
  logic [7:0]  wr_lo_reg;
  logic [7:0]  wr_hi_reg;

  cab_pkg::cab_op_e op;
  logic        accept;
  logic [7:0]  opb;
  logic [7:0]  logic_res;
  logic [7:0]  flags_next;
  logic        write_next;
  logic        word_next;
  logic        prod_next;
  logic [7:0]  lo_next;
  logic [7:0]  hi_next;
  logic [15:0] pc_next;
  logic [1:0]  cyc_next;
  logic        cond;
  logic        skip_cond;
  logic [15:0] pc_inc;
  logic [15:0] pc_rel;
  logic [15:0] pc_skip;

  assign op     = cab_pkg::cab_op_e'(op_in);
  assign accept = issue_in && (state_reg == ST_IDLE);
  assign opb    = use_imm_in ? imm_in : rr_val_in;
  assign pc_inc = pc_reg + 16'h0001;
  assign pc_rel = pc_reg + k_in + 16'h0001;
  assign pc_skip = pc_reg + (next_two_word_in ? 16'h0003 : 16'h0002);

  // operand routing into shared arithmetic
  always_comb begin
    alu.a     = rd_val_in;
    alu.b     = opb;
    alu.cin   = 1'b0;
    alu.sub   = 1'b1;
    alu.wa    = {rd_hi_in, rd_val_in};
    alu.wk    = imm_in[5:0];
    alu.wsub  = (op == cab_pkg::OP_WSUB);
    alu.ma    = rd_val_in;
    alu.mb    = rr_val_in;
    alu.msa   = 1'b0;
    alu.msb   = 1'b0;
    alu.mfrac = 1'b0;
    case (op)
      cab_pkg::OP_ADD: begin
        alu.sub = 1'b0;
      end
      cab_pkg::OP_ADC: begin
        alu.sub = 1'b0;
        alu.cin = status_flags_reg[cab_pkg::FLAG_C];
      end
      cab_pkg::OP_SUBC, cab_pkg::OP_CMPC: begin
        alu.cin = status_flags_reg[cab_pkg::FLAG_C];
      end
      cab_pkg::OP_SPROD, cab_pkg::OP_FSPROD: begin
        alu.msa = 1'b1;
        alu.msb = 1'b1;
      end
      cab_pkg::OP_SUPROD, cab_pkg::OP_FSUPROD: begin
        alu.msa = 1'b1;
      end
      default: begin
        alu.sub = 1'b1;
      end
    endcase
    if (op == cab_pkg::OP_FUPROD || op == cab_pkg::OP_FSPROD || op == cab_pkg::OP_FSUPROD) begin
      alu.mfrac = 1'b1;
    end
  end

  // logic unit results
  always_comb begin
    case (op)
      cab_pkg::OP_AND:     logic_res = rd_val_in & opb;
      cab_pkg::OP_OR:      logic_res = rd_val_in | opb;
      cab_pkg::OP_SETMASK: logic_res = rd_val_in | imm_in;
      cab_pkg::OP_CLRMASK: logic_res = rd_val_in & (cab_pkg::MASK_ALL - imm_in);
      cab_pkg::OP_TEST:    logic_res = rd_val_in & rd_val_in;
      cab_pkg::OP_ZERO:    logic_res = rd_val_in ^ rd_val_in;
      default:             logic_res = rd_val_in ^ rr_val_in;
    endcase
  end

  // branch and skip conditions
  always_comb begin
    skip_cond = 1'b0;
    cond      = 1'b0;
    case (op)
      cab_pkg::OP_CMPSKIP: skip_cond = (rd_val_in == rr_val_in);
      cab_pkg::OP_SKRC: skip_cond = ~rr_val_in[bit_sel_in];
      cab_pkg::OP_SKRS: skip_cond = rr_val_in[bit_sel_in];
      cab_pkg::OP_SKIC: skip_cond = ~io_val_in[bit_sel_in];
      cab_pkg::OP_SKIS: skip_cond = io_val_in[bit_sel_in];
      cab_pkg::OP_BRSET: cond = status_flags_reg[bit_sel_in];
      cab_pkg::OP_BRCLR: cond = ~status_flags_reg[bit_sel_in];
      cab_pkg::OP_SGEB: cond = ~(status_flags_reg[cab_pkg::FLAG_N] ^
                                 status_flags_reg[cab_pkg::FLAG_V]);
      cab_pkg::OP_SLTB: cond = status_flags_reg[cab_pkg::FLAG_N] ^
                               status_flags_reg[cab_pkg::FLAG_V];
      default: cond = 1'b0;
    endcase
  end

  // result, flags, pc and clock count per operation
  always_comb begin
    flags_next = status_flags_reg;
    write_next = 1'b0;
    word_next  = 1'b0;
    prod_next  = 1'b0;
    lo_next    = alu.sum;
    hi_next    = 8'h00;
    pc_next    = pc_inc;
    cyc_next   = cab_pkg::CYC_ONE;
    case (op)
      cab_pkg::OP_ADD, cab_pkg::OP_ADC, cab_pkg::OP_SUB, cab_pkg::OP_SUBC,
      cab_pkg::OP_CMP, cab_pkg::OP_CMPC: begin
        write_next = (op != cab_pkg::OP_CMP) && (op != cab_pkg::OP_CMPC);
        flags_next[cab_pkg::FLAG_Z] = (alu.sum == 8'h00);
        flags_next[cab_pkg::FLAG_C] = alu.cout;
        flags_next[cab_pkg::FLAG_N] = alu.sum[7];
        flags_next[cab_pkg::FLAG_V] = alu.vout;
        flags_next[cab_pkg::FLAG_H] = alu.hout;
        flags_next[cab_pkg::FLAG_S] = alu.sum[7] ^ alu.vout;
      end
      cab_pkg::OP_WADD, cab_pkg::OP_WSUB: begin
        write_next = 1'b1;
        word_next  = 1'b1;
        lo_next    = alu.wsum[7:0];
        hi_next    = alu.wsum[15:8];
        cyc_next   = cab_pkg::CYC_WORD;
        flags_next[cab_pkg::FLAG_Z] = (alu.wsum == 16'h0000);
        flags_next[cab_pkg::FLAG_C] = alu.wc;
        flags_next[cab_pkg::FLAG_N] = alu.wsum[15];
        flags_next[cab_pkg::FLAG_V] = alu.wv;
        flags_next[cab_pkg::FLAG_S] = alu.wsum[15] ^ alu.wv;
      end
      cab_pkg::OP_AND, cab_pkg::OP_OR, cab_pkg::OP_XOR, cab_pkg::OP_SETMASK,
      cab_pkg::OP_CLRMASK, cab_pkg::OP_TEST, cab_pkg::OP_ZERO: begin
        write_next = (op != cab_pkg::OP_TEST);
        lo_next    = logic_res;
        flags_next[cab_pkg::FLAG_Z] = (logic_res == 8'h00);
        flags_next[cab_pkg::FLAG_N] = logic_res[7];
        flags_next[cab_pkg::FLAG_V] = 1'b0;
        flags_next[cab_pkg::FLAG_S] = logic_res[7];
      end
      cab_pkg::OP_UPROD, cab_pkg::OP_SPROD, cab_pkg::OP_SUPROD, cab_pkg::OP_FUPROD,
      cab_pkg::OP_FSPROD, cab_pkg::OP_FSUPROD: begin
        write_next = 1'b1;
        prod_next  = 1'b1;
        lo_next    = alu.mprod[7:0];
        hi_next    = alu.mprod[15:8];
        cyc_next   = cab_pkg::CYC_MUL;
        flags_next[cab_pkg::FLAG_Z] = (alu.mprod == 16'h0000);
        flags_next[cab_pkg::FLAG_C] = alu.mc;
      end
      cab_pkg::OP_RELCALL: begin
        pc_next  = pc_rel;
        cyc_next = cab_pkg::CYC_CALL3;
      end
      cab_pkg::OP_PTRCALL: begin
        pc_next  = z_ptr_in;
        cyc_next = cab_pkg::CYC_CALL3;
      end
      cab_pkg::OP_CALL: begin
        pc_next  = k_in;
        cyc_next = cab_pkg::CYC_CALL4;
      end
      // skips, one extra clock per skipped word
      cab_pkg::OP_CMPSKIP, cab_pkg::OP_SKRC, cab_pkg::OP_SKRS, cab_pkg::OP_SKIC,
      cab_pkg::OP_SKIS: begin
        if (skip_cond) begin
          pc_next  = pc_skip;
          cyc_next = next_two_word_in ? 2'h2 : 2'h1;
        end
      end
      cab_pkg::OP_BRSET, cab_pkg::OP_BRCLR, cab_pkg::OP_SGEB, cab_pkg::OP_SLTB: begin
        if (cond) begin
          pc_next  = pc_rel;
          cyc_next = 2'h1;
        end
      end
      default: begin
        pc_next = pc_inc;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= ST_IDLE;
      wait_reg  <= 2'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (accept && cyc_next != cab_pkg::CYC_ONE) begin
            state_reg <= ST_WAIT;
            wait_reg  <= cyc_next;
          end
        end
        ST_WAIT: begin
          if (wait_reg == 2'h1) begin
            state_reg <= ST_IDLE;
          end
          wait_reg <= wait_reg - 2'h1;
        end
        default: begin
          state_reg <= ST_IDLE;
          wait_reg  <= 2'h0;
        end
      endcase
    end
  end

  // program counter and status flags
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pc_reg           <= cab_pkg::PC_RESET;
      status_flags_reg <= cab_pkg::STATUS_RESET;
    end else if (accept) begin
      pc_reg           <= pc_next;
      status_flags_reg <= flags_next;
    end
  end

  // writeback strobe and data
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_en_reg   <= 1'b0;
      wr_word_reg <= 1'b0;
      wr_prod_reg <= 1'b0;
      wr_lo_reg   <= 8'h00;
      wr_hi_reg   <= 8'h00;
    end else begin
      wr_en_reg   <= accept && write_next;
      wr_word_reg <= accept && word_next;
      wr_prod_reg <= accept && prod_next;
      if (accept) begin
        wr_lo_reg <= lo_next;
        wr_hi_reg <= hi_next;
      end
    end
  end

  assign wr_en_out            = wr_en_reg;
  assign wr_word_out          = wr_word_reg;
  assign wr_prod_out          = wr_prod_reg;
  assign wr_lo_out            = wr_lo_reg;
  assign wr_hi_out            = wr_hi_reg;
  assign pc_out               = pc_reg;
  assign busy_out             = state_reg[1];
  assign status_flags_reg_out = status_flags_reg;

  a_busy_word_len: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (accept && op == cab_pkg::OP_WADD) |=> busy_out ##1 !busy_out)
    else $error("word add busy length wrong");

  a_call_long: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (accept && op == cab_pkg::OP_CALL) |=> busy_out [*3] ##1 !busy_out)
    else $error("direct call not four clocks");

  a_relative_subroutine_jump_target: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (accept && op == cab_pkg::OP_RELCALL) |=> pc_out == $past(pc_rel))
    else $error("relative call target wrong");

  a_logic_keeps_c: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (accept && op == cab_pkg::OP_AND) |=> $stable(status_flags_reg_out[cab_pkg::FLAG_C]))
    else $error("logic op changed carry");

  a_cp_no_write: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (accept && op == cab_pkg::OP_CMP) |=> !wr_en_out)
    else $error("compare wrote register");

  a_zero_result: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (accept && op == cab_pkg::OP_ZERO) |=> wr_lo_out == 8'h00 && status_flags_reg_out[1])
    else $error("zero register result wrong");

  a_branch_ge: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (accept && op == cab_pkg::OP_SGEB && (status_flags_reg[2] == status_flags_reg[3]))
      |=> pc_out == $past(pc_rel) && busy_out)
    else $error("signed ge branch not taken");

  a_skip_flags: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (accept && op == cab_pkg::OP_CMPSKIP) |=> $stable(status_flags_reg_out))
    else $error("skip altered flags");

  a_mul_prod: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (accept && op == cab_pkg::OP_UPROD)
      |=> wr_prod_out && {wr_hi_out, wr_lo_out} == $past(rd_val_in) * $past(rr_val_in))
    else $error("unsigned product wrong");
endmodule // cab_core

/* File: cab_pkg.sv */
package cab_pkg;
  // operation codes presented by the decoder
  typedef enum logic [5:0] {
    OP_NOP      = 6'h00,
    OP_ADD      = 6'h01,
    OP_ADC      = 6'h02,
    OP_SUB      = 6'h03,
    OP_SUBC     = 6'h04,
    OP_WADD     = 6'h05,
    OP_WSUB     = 6'h06,
    OP_AND      = 6'h07,
    OP_OR       = 6'h08,
    OP_XOR      = 6'h09,
    OP_SETMASK  = 6'h0A,
    OP_CLRMASK  = 6'h0B,
    OP_TEST     = 6'h0C,
    OP_ZERO     = 6'h0D,
    OP_UPROD    = 6'h0E,
    OP_SPROD    = 6'h0F,
    OP_SUPROD   = 6'h10,
    OP_FUPROD   = 6'h11,
    OP_FSPROD   = 6'h12,
    OP_FSUPROD  = 6'h13,
    OP_RELCALL  = 6'h14,
    OP_PTRCALL  = 6'h15,
    OP_CALL     = 6'h16,
    OP_CMP      = 6'h17,
    OP_CMPC     = 6'h18,
    OP_CMPSKIP  = 6'h19,
    OP_SKRC     = 6'h1A,
    OP_SKRS     = 6'h1B,
    OP_SKIC     = 6'h1C,
    OP_SKIS     = 6'h1D,
    OP_BRSET    = 6'h1E,
    OP_BRCLR    = 6'h1F,
    OP_SGEB     = 6'h20,
    OP_SLTB     = 6'h21
  } cab_op_e;

  // status flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;

  localparam logic [7:0]  STATUS_RESET = 8'h00;
  localparam logic [15:0] PC_RESET     = 16'h0000;
  localparam logic [7:0]  MASK_ALL     = 8'hFF;

  // wait clocks after the issue clock (clock count minus one)
  localparam logic [1:0] CYC_ONE   = 2'h0;
  localparam logic [1:0] CYC_WORD  = 2'h1;
  localparam logic [1:0] CYC_MUL   = 2'h1;
  localparam logic [1:0] CYC_CALL3 = 2'h2;
  localparam logic [1:0] CYC_CALL4 = 2'h3;
endpackage : cab_pkg

/* File: cab_alu_if.sv */
`timescale 1ns/1ps
interface cab_alu_if;
  logic [7:0]  a;
  logic [7:0]  b;
  logic        cin;
  logic        sub;
  logic [7:0]  sum;
  logic        cout;
  logic        hout;
  logic        vout;
  logic [15:0] wa;
  logic [5:0]  wk;
  logic        wsub;
  logic [15:0] wsum;
  logic        wc;
  logic        wv;
  logic [7:0]  ma;
  logic [7:0]  mb;
  logic        msa;
  logic        msb;
  logic        mfrac;
  logic [15:0] mprod;
  logic        mc;
  modport core (output a, b, cin, sub, wa, wk, wsub, ma, mb, msa, msb, mfrac,
                input sum, cout, hout, vout, wsum, wc, wv, mprod, mc);
  modport adder (input a, b, cin, sub, wa, wk, wsub,
                 output sum, cout, hout, vout, wsum, wc, wv);
  modport mult (input ma, mb, msa, msb, mfrac, output mprod, mc);
endinterface : cab_alu_if

/* File: cab_adder.sv */
`timescale 1ns/1ps
module cab_adder (
  cab_alu_if.adder bus
);
  logic [8:0] full;
  logic [4:0] half;
  logic [7:0] bx;
  logic       ci;
  logic [16:0] wfull;

  // byte add or subtract with borrow
  always_comb begin
    bx   = bus.sub ? ~bus.b : bus.b;
    ci   = bus.sub ? ~bus.cin : bus.cin;
    full = {1'b0, bus.a} + {1'b0, bx} + {8'h00, ci};
    half = {1'b0, bus.a[3:0]} + {1'b0, bx[3:0]} + {4'h0, ci};
    bus.sum  = full[7:0];
    bus.cout = bus.sub ? ~full[8] : full[8];
    bus.hout = bus.sub ? ~half[4] : half[4];
    bus.vout = (bus.a[7] == bx[7]) && (full[7] != bus.a[7]);
  end

  // word add or subtract of a small constant
  always_comb begin
    if (bus.wsub) begin
      wfull = {1'b0, bus.wa} - {11'h000, bus.wk};
    end else begin
      wfull = {1'b0, bus.wa} + {11'h000, bus.wk};
    end
    bus.wsum = wfull[15:0];
    bus.wc   = wfull[16];
    bus.wv   = bus.wsub ? (bus.wa[15] & ~wfull[15]) : (~bus.wa[15] & wfull[15]);
  end
endmodule // cab_adder

/* File: cab_mult.sv */
`timescale 1ns/1ps
module cab_mult (
  cab_alu_if.mult bus
);
  logic signed [8:0]  ea;
  logic signed [8:0]  eb;
  logic signed [17:0] p;

  // signed or unsigned operands, optional fraction shift
  always_comb begin
    ea = bus.msa ? $signed({bus.ma[7], bus.ma}) : $signed({1'b0, bus.ma});
    eb = bus.msb ? $signed({bus.mb[7], bus.mb}) : $signed({1'b0, bus.mb});
    p  = ea * eb;
    bus.mc    = p[15];
    bus.mprod = bus.mfrac ? {p[14:0], 1'b0} : p[15:0];
  end
endmodule // cab_mult

/* File: cab_rf_model.sv */
`timescale 1ns/1ps
module cab_rf_model (
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       rst_n_in,
  // writeback from core
  input  wire logic       wr_en_in,
  input  wire logic       wr_word_in,
  input  wire logic       wr_prod_in,
  input  wire logic [4:0] dst_in,
  input  wire logic [7:0] lo_in,
  input  wire logic [7:0] hi_in,
  // read of destination
  output logic      [7:0] lo_out,
  output logic      [7:0] hi_out
);
  logic [7:0] regs_reg [32];

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < 32; i++) regs_reg[i] <= 8'h00;
    end else if (wr_en_in) begin
      if (wr_prod_in) begin
        regs_reg[0] <= lo_in;
        regs_reg[1] <= hi_in;
      end else begin
        regs_reg[dst_in] <= lo_in;
        if (wr_word_in) regs_reg[dst_in + 5'h01] <= hi_in;
      end
    end
  end

  assign lo_out = regs_reg[dst_in];
  assign hi_out = regs_reg[dst_in + 5'h01];
endmodule // cab_rf_model

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [7:0]  rd;
    logic [7:0]  rr;
    logic [7:0]  rdh;
    logic [7:0]  imm;
    logic [2:0]  bs;
    logic [7:0]  io;
    logic [15:0] k;
    logic [15:0] z;
    logic        ui;
    logic        tw;
    logic [4:0]  dst;
  } cab_tb_in_s;
  localparam int W     = $bits(cab_tb_in_s);
  localparam int LIMIT = 30000;
  logic        clk       = 1'b0;
  logic        rst_n     = 1'b0;
  logic        issue     = 1'b0;
  logic [5:0]  op        = 6'h00;
  cab_tb_in_s  din       = '0;
  cab_tb_in_s  nx;
  logic        wr_en, wr_word, wr_prod, busy, c;
  logic [7:0]  wr_lo, wr_hi, flags, m_lo, m_hi, b8, r8;
  logic [15:0] pc, a16, b16, p16, r16;
  logic [16:0] t17;
  logic [7:0]  ef        = cab_pkg::STATUS_RESET;
  logic [15:0] epc       = cab_pkg::PC_RESET;
  logic [7:0]  cor [6]   = '{8'h00, 8'h0F, 8'h7F, 8'h80, 8'hFF, 8'h10};
  int          err_count = 0;
  int          checks    = 0;
  int          cyc_cnt   = 0;
  int          j;
  cab_pkg::cab_op_e aops [6] = '{cab_pkg::OP_ADD, cab_pkg::OP_ADC, cab_pkg::OP_SUB,
    cab_pkg::OP_SUBC, cab_pkg::OP_CMP, cab_pkg::OP_CMPC};
  cab_pkg::cab_op_e lops [7] = '{cab_pkg::OP_AND, cab_pkg::OP_OR, cab_pkg::OP_XOR,
    cab_pkg::OP_SETMASK, cab_pkg::OP_CLRMASK, cab_pkg::OP_TEST, cab_pkg::OP_ZERO};
  cab_pkg::cab_op_e mops [6] = '{cab_pkg::OP_UPROD, cab_pkg::OP_SPROD, cab_pkg::OP_SUPROD,
    cab_pkg::OP_FUPROD, cab_pkg::OP_FSPROD, cab_pkg::OP_FSUPROD};
  cab_pkg::cab_op_e fops [9] = '{cab_pkg::OP_RELCALL, cab_pkg::OP_PTRCALL, cab_pkg::OP_CALL,
    cab_pkg::OP_CMPSKIP, cab_pkg::OP_SKRC, cab_pkg::OP_SKRS, cab_pkg::OP_SKIC,
    cab_pkg::OP_SKIS, cab_pkg::OP_BRSET};
  cab_pkg::cab_op_e bops [3] = '{cab_pkg::OP_BRCLR, cab_pkg::OP_SGEB, cab_pkg::OP_SLTB};

  always #5 clk = ~clk;

  cab_core u_dut (
    .sys_clk_in(clk), .rst_n_in(rst_n), .issue_in(issue), .op_in(op),
    .rd_val_in(din.rd), .rr_val_in(din.rr), .rd_hi_in(din.rdh), .imm_in(din.imm),
    .bit_sel_in(din.bs), .io_val_in(din.io), .k_in(din.k), .z_ptr_in(din.z),
    .use_imm_in(din.ui), .next_two_word_in(din.tw), .wr_en_out(wr_en),
    .wr_word_out(wr_word), .wr_prod_out(wr_prod), .wr_lo_out(wr_lo), .wr_hi_out(wr_hi),
    .pc_out(pc), .busy_out(busy), .status_flags_reg_out(flags));

  cab_rf_model u_rf (
    .sys_clk_in(clk), .rst_n_in(rst_n), .wr_en_in(wr_en), .wr_word_in(wr_word),
    .wr_prod_in(wr_prod), .dst_in(din.dst), .lo_in(wr_lo), .hi_in(wr_hi),
    .lo_out(m_lo), .hi_out(m_hi));

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == LIMIT) begin
      err_count++;
      give_verdict();
    end
  end

  function automatic cab_tb_in_s rnd();
    return W'({$urandom, $urandom, $urandom});
  endfunction

  // new flags: masked bits replaced, sign is n xor v
  function automatic logic [7:0] nf(input logic [7:0] m, input logic fc, fz, fn, fv, fh);
    logic [7:0] f;
    f = ef;
    f[cab_pkg::FLAG_C] = fc;
    f[cab_pkg::FLAG_Z] = fz;
    f[cab_pkg::FLAG_N] = fn;
    f[cab_pkg::FLAG_V] = fv;
    f[cab_pkg::FLAG_S] = fn ^ fv;
    f[cab_pkg::FLAG_H] = fh;
    return (ef & ~m) | (f & m);
  endfunction

  task automatic go(input logic [5:0] o, input int cyc, input logic [7:0] fm,
                    input logic [2:0] w, input logic [15:0] wv, input logic [15:0] np);
    int n;
    @(posedge clk);
    issue <= 1'b1;
    op    <= o;
    din   <= nx;
    @(posedge clk);
    issue <= 1'b0;
    #1;
    epc = np;
    chk({8'h00, flags & fm}, {8'h00, ef & fm});
    chk(pc, epc);
    chk({13'h0000, wr_en, wr_word, wr_prod}, {13'h0000, w});
    if (w[2]) chk((w[1] | w[0]) ? {wr_hi, wr_lo} : {8'h00, wr_lo}, wv);
    n = 0;
    while (busy === 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(16'(n), 16'(cyc - 1));
    if (w[2]) begin
      @(posedge clk);
      #1;
      chk((w[1] | w[0]) ? {m_hi, m_lo} : {8'h00, m_lo}, wv);
    end
  endtask

  task automatic do_ar(input int k, input int i);
    logic [8:0] t;
    logic [4:0] h;
    logic       ci;
    nx = rnd();
    if (i < 6) {nx.rd, nx.rr, nx.ui} = {cor[i], 8'h01, 1'b0};
    if (k < 2 || k == 5) nx.ui = 1'b0;
    b8 = nx.ui ? nx.imm : nx.rr;
    ci = (k % 2 == 1) ? ef[cab_pkg::FLAG_C] : 1'b0;
    t = (k >= 2) ? {1'b0, nx.rd} - {1'b0, b8} - 9'(ci) : {1'b0, nx.rd} + {1'b0, b8} + 9'(ci);
    h = (k >= 2) ? {1'b0, nx.rd[3:0]} - {1'b0, b8[3:0]} - 5'(ci)
                 : {1'b0, nx.rd[3:0]} + {1'b0, b8[3:0]} + 5'(ci);
    ef = nf(8'h3F, t[8], t[7:0] == 8'h00, t[7], ((k >= 2) ^ ~(nx.rd[7] ^ b8[7]))
            & (nx.rd[7] ^ t[7]), h[4]);
    go(aops[k], 1, 8'h2F, (k < 4) ? 3'b100 : 3'b000, {8'h00, t[7:0]}, epc + 16'h0001);
  endtask

  initial begin
    void'($urandom(13442));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk(pc, cab_pkg::PC_RESET);
    chk({flags, 6'h00, busy, wr_en}, {cab_pkg::STATUS_RESET, 8'h00});
    for (int i = 0; i < 60; i++) do_ar((i < 6) ? i : int'($urandom % 6), i);
    $display("test arith done");
    for (int i = 0; i < 30; i++) begin
      nx = rnd();
      nx.dst[0] = 1'b0;
      j = i % 2;
      if (i < 2) {nx.rdh, nx.rd, nx.imm} = {(i == 1) ? 16'h8000 : 16'hFFFF, 8'h01};
      a16 = {nx.rdh, nx.rd};
      t17 = (j == 1) ? {1'b0, a16} - 17'(nx.imm[5:0]) : {1'b0, a16} + 17'(nx.imm[5:0]);
      ef = nf(8'h1F, t17[16], t17[15:0] == 16'h0000, t17[15],
              (j == 1) ? a16[15] & ~t17[15] : ~a16[15] & t17[15], 1'b0);
      go((j == 1) ? cab_pkg::OP_WSUB : cab_pkg::OP_WADD, 2, 8'h1F, 3'b110, t17[15:0],
         epc + 16'h0001);
    end
    $display("test word done");
    for (int i = 0; i < 35; i++) begin
      nx = rnd();
      j = i % 7;
      if (j >= 2) nx.ui = (j == 3 || j == 4);
      b8 = nx.ui ? nx.imm : nx.rr;
      case (j)
        0: r8 = nx.rd & b8;
        1: r8 = nx.rd | b8;
        2: r8 = nx.rd ^ b8;
        3: r8 = nx.rd | nx.imm;
        4: r8 = nx.rd & (cab_pkg::MASK_ALL - nx.imm);
        5: r8 = nx.rd & nx.rd;
        default: r8 = 8'h00;
      endcase
      ef = nf(8'h1E, 1'b0, r8 == 8'h00, r8[7], 1'b0, 1'b0);
      go(lops[j], 1, 8'h1F, (j == 5) ? 3'b000 : 3'b100, {8'h00, r8}, epc + 16'h0001);
    end
    $display("test logic done");
    for (int i = 0; i < 30; i++) begin
      nx = rnd();
      nx.dst = 5'h00;
      j = i % 6;
      if (i < 6) {nx.rd, nx.rr} = 16'h8080;
      a16 = (j % 3 != 0) ? {{8{nx.rd[7]}}, nx.rd} : {8'h00, nx.rd};
      b16 = (j % 3 == 1) ? {{8{nx.rr[7]}}, nx.rr} : {8'h00, nx.rr};
      p16 = a16 * b16;
      r16 = (j >= 3) ? p16 << 1 : p16;
      ef = nf(8'h03, p16[15], r16 == 16'h0000, 1'b0, 1'b0, 1'b0);
      go(mops[j], 2, 8'h6F, 3'b101, r16, epc + 16'h0001);
    end
    $display("test multiply done");
    for (int i = 0; i < 48; i++) begin
      nx = rnd();
      j = i % 8;
      if ($urandom % 2 == 1) nx.rr = nx.rd;
      if (j == 4 || j == 5) nx.rd = nx.rr;
      case (j)
        3: c = nx.rd == nx.rr;
        4: c = !nx.rr[nx.bs];
        5: c = nx.rr[nx.bs];
        6: c = !nx.io[nx.bs];
        default: c = nx.io[nx.bs];
      endcase
      if (j < 3) begin
        go(fops[j], (j == 2) ? 4 : 3, 8'h6F, 3'b000, 16'h0000,
           (j == 0) ? epc + nx.k + 16'h0001 : (j == 1) ? nx.z : nx.k);
      end else begin
        go(fops[j], c ? 2 + int'(nx.tw) : 1, 8'h6F, 3'b000, 16'h0000,
           epc + (c ? 16'h0002 + 16'(nx.tw) : 16'h0001));
      end
    end
    $display("test flow done");
    for (int i = 0; i < 48; i++) begin
      do_ar(int'($urandom % 6), 99);
      nx = rnd();
      j = i % 4;
      if (nx.bs == 3'h7) nx.bs = 3'h6;
      case (j)
        0: c = ef[nx.bs];
        1: c = !ef[nx.bs];
        2: c = !(ef[cab_pkg::FLAG_N] ^ ef[cab_pkg::FLAG_V]);
        default: c = ef[cab_pkg::FLAG_N] ^ ef[cab_pkg::FLAG_V];
      endcase
      go((j == 0) ? fops[8] : bops[j - 1], c ? 2 : 1, 8'h6F, 3'b000, 16'h0000,
         c ? epc + nx.k + 16'h0001 : epc + 16'h0001);
    end
    $display("test branch done");
    give_verdict();
  end
endmodule // tb_top
